// *** verification/flash_cmd_props.sv ***
// Checker for suspend screening, latch and one-time write behaviour
`timescale 1ns/1ps

module flash_cmd_props (
	input wire logic        CLK_I,
	input wire logic        RESET_I,
	input wire logic        PROG_SUSP_I,
	input wire logic        ERASE_SUSP_I,
	input wire logic        OTP_LOCKED_I,
	input wire logic [7:0]  OTP_OLD_I,
	input wire logic        CMD_STB_O,
	input wire logic [7:0]  CMD_CODE_O,
	input wire logic        CMD_BANK_O,
	input wire logic        CMD_DROP_O,
	input wire logic        OTP_WR_STB_O,
	input wire logic [7:0]  OTP_WR_DATA_O,
	input wire logic [23:0] OTP_ADDR_O,
	input wire logic        WEL_O,
	input wire logic        PERR_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	// Admission events per suspend state and one-time write events
	sequence ps_admit_s; CMD_STB_O && PROG_SUSP_I; endsequence
	sequence es_admit_s; CMD_STB_O && ERASE_SUSP_I && !PROG_SUSP_I; endsequence
	sequence otp_write_s; OTP_WR_STB_O; endsequence

	ps_table_a: assert property (ps_admit_s |-> CMD_CODE_O inside {
		8'hb9, 8'h16, 8'h17, 8'h0b, 8'h0c, 8'hff, 8'h8a, 8'h13, 8'h35, 8'hed,
		8'hee, 8'heb, 8'hec, 8'h6b, 8'h6c, 8'h05, 8'h07, 8'h03, 8'hf0, 8'h01})
		else $error("opcode admitted in program suspend");
	es_table_a: assert property (es_admit_s |-> CMD_CODE_O inside {
		8'hb9, 8'h16, 8'h17, 8'h0b, 8'h0c, 8'hff, 8'h8a, 8'h13, 8'h35, 8'hed,
		8'hee, 8'heb, 8'hec, 8'h6b, 8'h6c, 8'h05, 8'h07, 8'h03, 8'hf0, 8'h01,
		8'h30, 8'he0, 8'he1, 8'h7a, 8'h85, 8'h02, 8'h12, 8'he2, 8'h32, 8'h38,
		8'h34, 8'h06}) else $error("opcode admitted in erase suspend");
	drop_susp_a: assert property (CMD_DROP_O |-> (PROG_SUSP_I || ERASE_SUSP_I))
		else $error("opcode dropped outside suspend");
	bank_write_a: assert property (CMD_BANK_O |-> CMD_STB_O && CMD_CODE_O == 8'h01)
		else $error("bank write flag without register write");
	wel_set_a: assert property (CMD_STB_O && CMD_CODE_O == 8'h06 |-> ##[0:1] WEL_O)
		else $error("write enable did not set latch");
	otp_wel_a: assert property (otp_write_s |-> WEL_O)
		else $error("one-time write without latch");
	otp_merge_a: assert property (otp_write_s |-> (OTP_WR_DATA_O & ~$past(OTP_OLD_I)) == 8'h00)
		else $error("one-time write sets an already cleared bit");
	otp_addr_a: assert property (otp_write_s |-> OTP_ADDR_O == $past(OTP_ADDR_O) + 24'h1)
		else $error("one-time address did not advance");
	perr_lock_a: assert property ($rose(PERR_O) |-> $past(OTP_LOCKED_I) && !OTP_WR_STB_O)
		else $error("program error without locked region");
endmodule // flash_cmd_props

bind flash_suspend_cmd flash_cmd_props u_props (
	.CLK_I, .RESET_I, .PROG_SUSP_I, .ERASE_SUSP_I, .OTP_LOCKED_I, .OTP_OLD_I,
	.CMD_STB_O, .CMD_CODE_O, .CMD_BANK_O, .CMD_DROP_O, .OTP_WR_STB_O,
	.OTP_WR_DATA_O, .OTP_ADDR_O, .WEL_O, .PERR_O
);

// *** verification/spi_host_model.sv ***
// Mode 0 serial host that shifts whole frames and collects the device output
`timescale 1ns/1ps

module spi_host_model (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o
);
	// Idle: clock low, select high
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b1;
	end

	// One frame; data goes out msb first, 320 ns link clock, output sampled mid-high
	task automatic xfer(input logic [127:0] tx, input int nbits, output logic [127:0] rx);
		rx = '0;
		@(posedge clk_i) cs_n_o <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			@(posedge clk_i);
			sck_o <= 1'b0;
			si_o <= tx[127-i];
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			repeat (2) @(posedge clk_i);
			rx = {rx[126:0], so_i};
			@(posedge clk_i);
		end
		@(posedge clk_i) sck_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// Released data line shows the inverse of its last value
		si_o <= ~si_o;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // spi_host_model

// *** verification/tb_flash_suspend_otp_asp_cmds.sv ***
// Testbench for the suspend-aware serial command front end
`timescale 1ns/1ps

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %0h got %0h", nm, (e), (g)); end end

module tb_flash_suspend_otp_asp_cmds;
	logic        CLK_I, RESET_I, SCK_I, CS_N_I, SI_I, SO_O, SO_OE_O, WIP_I;
	logic        PROG_SUSP_I, ERASE_SUSP_I, OTP_LOCKED_I, RD_VALID_I, RD_READY_O;
	logic        RD_START_O, CMD_STB_O, CMD_BANK_O, CMD_DROP_O, OTP_WR_STB_O;
	logic        WEL_O, PERR_O, last_bank;
	logic [15:0] SECTOR_PROT_I;
	logic [7:0]  CONFIG_I, OTP_OLD_I, RD_DATA_I, CMD_CODE_O, OTP_WR_DATA_O;
	logic [23:0] OTP_ADDR_O;
	logic [127:0] rx;
	logic [31:0] wq[$];
	int          num_errors, total_checks, n_stb, n_drop, n_oe;
	logic [7:0]  ops [34] = '{8'hb9, 8'h16, 8'h17, 8'h0b, 8'h0c, 8'hff, 8'h8a, 8'h13,
		8'h35, 8'hed, 8'hee, 8'heb, 8'hec, 8'h6b, 8'h6c, 8'h05, 8'h07, 8'h03, 8'hf0,
		8'h30, 8'he0, 8'he1, 8'h7a, 8'h85, 8'h02, 8'h12, 8'he2, 8'h32, 8'h38, 8'h34,
		8'h06, 8'h2b, 8'h42, 8'h4b};

	always #20 CLK_I = ~CLK_I;

	flash_suspend_cmd DUT (.CLK_I, .RESET_I, .SCK_I, .CS_N_I, .SI_I, .SO_O, .SO_OE_O,
		.WIP_I, .PROG_SUSP_I, .ERASE_SUSP_I, .SECTOR_PROT_I, .CONFIG_I, .OTP_LOCKED_I,
		.OTP_OLD_I, .RD_DATA_I, .RD_VALID_I, .RD_READY_O, .RD_START_O, .CMD_STB_O,
		.CMD_CODE_O, .CMD_BANK_O, .CMD_DROP_O, .OTP_WR_STB_O, .OTP_WR_DATA_O,
		.OTP_ADDR_O, .WEL_O, .PERR_O);

	spi_host_model host (.clk_i(CLK_I), .so_i(SO_O), .sck_o(SCK_I), .cs_n_o(CS_N_I),
		.si_o(SI_I));

	// Count admission pulses and log one-time writes
	always @(posedge CLK_I) begin
		if (CMD_STB_O) begin
			n_stb++;
			last_bank = CMD_BANK_O;
		end
		if (CMD_DROP_O) n_drop++;
		if (SO_OE_O) n_oe++;
		if (OTP_WR_STB_O) wq.push_back({OTP_ADDR_O, OTP_WR_DATA_O});
	end

	task automatic send(input logic [127:0] tx, input int n);
		n_stb = 0;
		n_drop = 0;
		n_oe = 0;
		host.xfer(tx, n, rx);
	endtask

	task automatic susp(input logic es, input logic ps);
		@(posedge CLK_I);
		ERASE_SUSP_I <= es;
		PROG_SUSP_I <= ps;
	endtask

	// Register read: opcode then sixteen output bits
	task automatic rd(input logic [7:0] op, input logic [15:0] e);
		send({op, 120'h0}, 24);
		`CHK("read", e, rx[15:0]);
		`CHK("drive", 2'b10, {n_oe != 0, SO_OE_O});
	endtask

	// Every table opcode in both suspend states, plus bank-follow rule
	task automatic t_admit;
		logic e;
		for (int s = 0; s < 2; s++) begin
			susp(s == 0, s == 1);
			for (int i = 0; i < 34; i++) begin
				e = (i < 19) || (s == 0 && i < 31);
				send({ops[i], 120'h0}, 8);
				`CHK("admit", {e, !e}, {n_stb == 1, n_drop == 1});
			end
		end
		send({8'hb9, 120'h0}, 8);
		send({8'h01, 120'h0}, 8);
		`CHK("bank write", 2'b11, {n_stb == 1, last_bank});
		send({8'h01, 120'h0}, 8);
		`CHK("lone write regs", 1'b1, n_drop == 1);
	endtask

	task automatic t_status;
		susp(1'b0, 1'b0);
		@(posedge CLK_I) WIP_I <= 1'b1;
		send({8'h06, 120'h0}, 8);
		rd(8'h05, 16'h0303);
		@(posedge CLK_I) WIP_I <= 1'b0;
		susp(1'b1, 1'b1);
		rd(8'h07, 16'h0303);
		susp(1'b1, 1'b0);
		rd(8'h07, 16'h0202);
		rd(8'h35, 16'h5a5a);
		susp(1'b0, 1'b0);
		send({8'h2b, 120'h0}, 40);
		`CHK("prot word", 32'h34123412, rx[31:0]);
	endtask

	task automatic t_otp_write;
		send({8'h06, 120'h0}, 8);
		send({8'h42, 24'h000010, 8'hf0, 8'h0f, 80'h0}, 48);
		`CHK("writes", 64'h0000_1130_0000_120c, {wq[0], wq[1]});
		`CHK("latch end", 1'b0, WEL_O);
		wq.delete();
		send({8'h42, 24'h000020, 8'h00, 88'h0}, 40);
		`CHK("no latch", 0, wq.size());
		@(posedge CLK_I) OTP_LOCKED_I <= 1'b1;
		send({8'h06, 120'h0}, 8);
		send({8'h42, 24'h000000, 8'hff, 88'h0}, 40);
		`CHK("locked ones", 2'b00, {PERR_O, wq.size() != 0});
		send({8'h06, 120'h0}, 8);
		send({8'h42, 24'h000000, 8'h7f, 88'h0}, 40);
		`CHK("locked zeros", 2'b10, {PERR_O, wq.size() != 0});
		@(posedge CLK_I) OTP_LOCKED_I <= 1'b0;
		susp(1'b1, 1'b0);
		send({8'h30, 120'h0}, 8);
		`CHK("clear status", 1'b0, PERR_O);
		susp(1'b0, 1'b0);
	endtask

	// Fill the buffer until it refuses, then drain it past empty
	task automatic t_otp_read;
		int acc;
		acc = 0;
		fork
			send({8'h4b, 24'h0, 96'h0}, 112);
			begin
				for (int t = 0; t < 2000 && RD_START_O !== 1'b1; t++) @(posedge CLK_I);
				RD_VALID_I <= 1'b1;
				RD_DATA_I <= 8'h10;
				repeat (10) begin
					@(posedge CLK_I);
					if (RD_READY_O === 1'b1) acc++;
					RD_DATA_I <= 8'h10 + 8'(acc);
				end
				RD_VALID_I <= 1'b0;
			end
		join
		`CHK("accepted", 8, acc);
		`CHK("read data", 72'h1011121314151617ff, rx[71:0]);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		#2000000;
		num_errors++;
		test_done;
	end

	initial begin
		{CLK_I, WIP_I, PROG_SUSP_I, ERASE_SUSP_I, OTP_LOCKED_I, RD_VALID_I} = '0;
		{SECTOR_PROT_I, CONFIG_I, OTP_OLD_I, RD_DATA_I} = {16'h1234, 8'h5a, 8'h3c, 8'h00};
		RESET_I = 1'b1;
		repeat (8) @(posedge CLK_I);
		RESET_I <= 1'b0;
		repeat (4) @(posedge CLK_I);
		t_admit;
		t_status;
		t_otp_write;
		t_otp_read;
		test_done;
	end
endmodule // tb_flash_suspend_otp_asp_cmds

// *** verilog/byte_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             flush_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             ready_reg;
	logic             push;
	logic             pop;

	// Handshakes; a flush blocks any push in flight
	assign push        = in_valid_i & ready_reg & ~flush_i;
	assign pop         = out_valid_o & out_ready_i & ~flush_i;
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign in_ready_o  = ready_reg;

	// Occupancy after this cycle
	always_comb begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + CW'(1);
		else if (pop && !push)
			count_next = count_reg - CW'(1);
	end

	// Storage
	always_ff @(posedge clk_i) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data_i;
	end

	// Pointers, count and registered ready
	always_ff @(posedge clk_i) begin
		if (reset_i || flush_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= ~reset_i & ~flush_i;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
			count_reg <= count_next;
			ready_reg <= (count_next < CW'(DEPTH));
		end
	end

endmodule // byte_fifo

// *** verilog/flash_cmd_pkg.sv ***
// Opcodes, status bit positions and frame constants for the suspend-aware command front end
package flash_cmd_pkg;

	// Clock figures
	localparam int CLK_PERIOD_NS = 40;

	// Opcodes handled or screened by the front end
	localparam logic [7:0] OP_BANK_ACCESS  = 8'hb9;
	localparam logic [7:0] OP_BANK_READ    = 8'h16;
	localparam logic [7:0] OP_BANK_WRITE   = 8'h17;
	localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
	localparam logic [7:0] OP_VPROT_READ   = 8'he0;
	localparam logic [7:0] OP_VPROT_WRITE  = 8'he1;
	localparam logic [7:0] OP_ERASE_RESUME = 8'h7a;
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] OP_READ_A32     = 8'h13;
	localparam logic [7:0] OP_QREAD        = 8'h0b;
	localparam logic [7:0] OP_QREAD_A32    = 8'h0c;
	localparam logic [7:0] OP_QOUT_READ    = 8'h6b;
	localparam logic [7:0] OP_QOUT_A32     = 8'h6c;
	localparam logic [7:0] OP_QIO_READ     = 8'heb;
	localparam logic [7:0] OP_QIO_A32      = 8'hec;
	localparam logic [7:0] OP_DDR_QIO      = 8'hed;
	localparam logic [7:0] OP_DDR_QIO_A32  = 8'hee;
	localparam logic [7:0] OP_MODE_RESET   = 8'hff;
	localparam logic [7:0] OP_PROG_RESUME  = 8'h8a;
	localparam logic [7:0] OP_PROG_SUSPEND = 8'h85;
	localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
	localparam logic [7:0] OP_PAGE_A32     = 8'h12;
	localparam logic [7:0] OP_QPAGE_WRITE  = 8'h32;
	localparam logic [7:0] OP_QPAGE_ALT    = 8'h38;
	localparam logic [7:0] OP_QPAGE_A32    = 8'h34;
	localparam logic [7:0] OP_PPROT_READ   = 8'he2;
	localparam logic [7:0] OP_STATUS1_READ = 8'h05;
	localparam logic [7:0] OP_STATUS2_READ = 8'h07;
	localparam logic [7:0] OP_CONFIG_READ  = 8'h35;
	localparam logic [7:0] OP_SOFT_RESET   = 8'hf0;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_REGS   = 8'h01;
	localparam logic [7:0] OP_ONETIME_WR   = 8'h42;
	localparam logic [7:0] OP_ONETIME_RD   = 8'h4b;
	localparam logic [7:0] OP_SPROT_READ   = 8'h2b;

	// Status register bit positions
	localparam int SR1_WIP_BIT  = 0;
	localparam int SR1_WEL_BIT  = 1;
	localparam int SR1_PERR_BIT = 6;
	localparam int SR2_PS_BIT   = 0;
	localparam int SR2_ES_BIT   = 1;

	// Frame shape
	localparam logic [1:0] ADDR_LAST_IDX = 2'h2;
	localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
	localparam logic [3:0] WORD_LAST_BIT = 4'hf;
	localparam logic [7:0] FILL_BYTE     = 8'hff;

	// Reset values
	localparam logic       WEL_RESET  = 1'b0;
	localparam logic       PERR_RESET = 1'b0;

	// Read-out sources
	typedef enum logic [1:0] {
		SRC_STATUS1,
		SRC_STATUS2,
		SRC_CONFIG,
		SRC_SECTOR_PROT
	} read_src_t;

endpackage

// *** verilog/flash_suspend_cmd.sv ***
// Serial command front end: suspend screening, one-time region access, sector protection read
`timescale 1ns/1ps

// Overview of operation
// - Bank register commands allowed in both suspends
// - Clear status allowed in erase suspend only
// - Volatile protection access in erase suspend only
// - Erase resume allowed in erase suspend only
// - All array reads allowed in both suspends
// - Mode bit reset allowed in both suspends
// - Program resume allowed in both, also nested
// - Program suspend allowed only in erase suspend
// - Page writes allowed in erase suspend only
// - Persistent protection read in erase suspend only
// - Status one and config reads always allowed
// - Status two read always allowed
// - Write enable allowed in erase suspend only
// - Register write in a suspend only right after bank access
// - One-time write needs write enable latch set
// - Zeros into locked region flag program error
// - One-time write only clears still-erased bits
// - One-time read does not wrap at top
// - One-time read always one dummy byte
// - Protection word sent low byte first
// - Protection word repeats every sixteen clocks
// - Write in progress at status one bit 0
// - Program suspended at status two bit 0
// - Erase suspended at status two bit 1
module flash_suspend_cmd #(
	parameter int FIFO_WIDTH = 8,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic        SCK_I,
	input  wire logic        CS_N_I,
	input  wire logic        SI_I,
	output logic             SO_O,
	output logic             SO_OE_O,
	input  wire logic        WIP_I,
	input  wire logic        PROG_SUSP_I,
	input  wire logic        ERASE_SUSP_I,
	input  wire logic [15:0] SECTOR_PROT_I,
	input  wire logic [7:0]  CONFIG_I,
	input  wire logic        OTP_LOCKED_I,
	input  wire logic [7:0]  OTP_OLD_I,
	input  wire logic [7:0]  RD_DATA_I,
	input  wire logic        RD_VALID_I,
	output logic             RD_READY_O,
	output logic             RD_START_O,
	output logic             CMD_STB_O,
	output logic [7:0]       CMD_CODE_O,
	output logic             CMD_BANK_O,
	output logic             CMD_DROP_O,
	output logic             OTP_WR_STB_O,
	output logic [7:0]       OTP_WR_DATA_O,
	output logic [23:0]      OTP_ADDR_O,
	output logic             WEL_O,
	output logic             PERR_O
);

	typedef enum {
		ST_OPCODE,
		ST_ADDR,
		ST_DUMMY,
		ST_WDATA,
		ST_RDOUT,
		ST_OTPOUT,
		ST_SKIP
	} frame_state_t;

	frame_state_t                 state_reg;
	flash_cmd_pkg::read_src_t     src_reg;
	logic                         sck_meta;
	logic                         sck_sync;
	logic                         sck_last;
	logic                         cs_meta;
	logic                         cs_sync;
	logic                         cs_last;
	logic                         si_meta;
	logic                         si_sync;
	logic                         sck_rise;
	logic                         sck_fall;
	logic                         frame_end;
	logic [2:0]                   bit_cnt_reg;
	logic [6:0]                   shift_reg;
	logic [7:0]                   rx_byte;
	logic                         byte_done;
	logic [1:0]                   addr_idx_reg;
	logic                         is_write_reg;
	logic                         bank_follow_reg;
	logic                         frame_bank_reg;
	logic                         frame_wrote_reg;
	logic                         admit;
	logic [15:0]                  out_sh_reg;
	logic [3:0]                   out_cnt_reg;
	logic [3:0]                   out_last;
	logic [15:0]                  out_word;
	logic [7:0]                   fifo_data;
	logic                         fifo_valid;
	logic                         fifo_pop;
	logic                         otp_zero_req;

	// Admission table by opcode and suspend state
	function automatic logic admit_fn(input logic [7:0] op, input logic ps,
			input logic es, input logic bank_follow);
		logic both;
		logic erase_only;
		both       = 1'b0;
		erase_only = 1'b0;
		case (op)
			flash_cmd_pkg::OP_BANK_ACCESS,
			flash_cmd_pkg::OP_BANK_READ,
			flash_cmd_pkg::OP_BANK_WRITE:   both = 1'b1;
			flash_cmd_pkg::OP_READ,
			flash_cmd_pkg::OP_READ_A32,
			flash_cmd_pkg::OP_QREAD,
			flash_cmd_pkg::OP_QREAD_A32,
			flash_cmd_pkg::OP_QOUT_READ,
			flash_cmd_pkg::OP_QOUT_A32,
			flash_cmd_pkg::OP_QIO_READ,
			flash_cmd_pkg::OP_QIO_A32,
			flash_cmd_pkg::OP_DDR_QIO,
			flash_cmd_pkg::OP_DDR_QIO_A32:  both = 1'b1;
			flash_cmd_pkg::OP_MODE_RESET:   both = 1'b1;
			flash_cmd_pkg::OP_PROG_RESUME:  both = 1'b1;
			flash_cmd_pkg::OP_STATUS1_READ,
			flash_cmd_pkg::OP_CONFIG_READ:  both = 1'b1;
			flash_cmd_pkg::OP_STATUS2_READ: both = 1'b1;
			flash_cmd_pkg::OP_SOFT_RESET:   both = 1'b1;
			flash_cmd_pkg::OP_WRITE_REGS:   both = bank_follow;
			flash_cmd_pkg::OP_CLEAR_STATUS: erase_only = 1'b1;
			flash_cmd_pkg::OP_VPROT_READ,
			flash_cmd_pkg::OP_VPROT_WRITE:  erase_only = 1'b1;
			flash_cmd_pkg::OP_ERASE_RESUME: erase_only = 1'b1;
			flash_cmd_pkg::OP_PROG_SUSPEND: erase_only = 1'b1;
			flash_cmd_pkg::OP_PAGE_WRITE,
			flash_cmd_pkg::OP_PAGE_A32,
			flash_cmd_pkg::OP_QPAGE_WRITE,
			flash_cmd_pkg::OP_QPAGE_ALT,
			flash_cmd_pkg::OP_QPAGE_A32:    erase_only = 1'b1;
			flash_cmd_pkg::OP_PPROT_READ:   erase_only = 1'b1;
			flash_cmd_pkg::OP_WRITE_ENABLE: erase_only = 1'b1;
			default: begin
				both       = 1'b0;
				erase_only = 1'b0;
			end
		endcase
		// Program suspend, nested or not, is the tighter table
		if (ps)
			return both;
		else if (es)
			return both | erase_only;
		else
			return 1'b1;
	endfunction

	// Two-stage synchronisers for the link pins
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			sck_meta <= 1'b0;
			sck_sync <= 1'b0;
			sck_last <= 1'b0;
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_last  <= 1'b1;
			si_meta  <= 1'b0;
			si_sync  <= 1'b0;
		end else begin
			sck_meta <= SCK_I;
			sck_sync <= sck_meta;
			sck_last <= sck_sync;
			cs_meta  <= CS_N_I;
			cs_sync  <= cs_meta;
			cs_last  <= cs_sync;
			si_meta  <= SI_I;
			si_sync  <= si_meta;
		end
	end

	// Link edges and assembled byte
	assign sck_rise  = sck_sync & ~sck_last & ~cs_sync;
	assign sck_fall  = ~sck_sync & sck_last & ~cs_sync;
	assign frame_end = cs_sync & ~cs_last;
	assign rx_byte   = {shift_reg, si_sync};
	assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);
	assign admit     = admit_fn(rx_byte, PROG_SUSP_I, ERASE_SUSP_I, bank_follow_reg);

	// Input bit counter and shifter, restarted by each frame
	always_ff @(posedge CLK_I) begin
		if (RESET_I || cs_sync) begin
			bit_cnt_reg <= '0;
			shift_reg   <= '0;
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg   <= rx_byte[6:0];
		end
	end

	// Frame state machine
	always_ff @(posedge CLK_I) begin
		if (RESET_I || cs_sync) begin
			state_reg    <= ST_OPCODE;
			addr_idx_reg <= '0;
			is_write_reg <= 1'b0;
		end else if (byte_done) begin
			case (state_reg)
				ST_OPCODE: begin
					addr_idx_reg <= '0;
					is_write_reg <= (rx_byte == flash_cmd_pkg::OP_ONETIME_WR);
					if (!admit)
						state_reg <= ST_SKIP;
					else
						case (rx_byte)
							flash_cmd_pkg::OP_STATUS1_READ,
							flash_cmd_pkg::OP_STATUS2_READ,
							flash_cmd_pkg::OP_CONFIG_READ,
							flash_cmd_pkg::OP_SPROT_READ: state_reg <= ST_RDOUT;
							flash_cmd_pkg::OP_ONETIME_RD: state_reg <= ST_ADDR;
							flash_cmd_pkg::OP_ONETIME_WR:
								state_reg <= WEL_O ? ST_ADDR : ST_SKIP;
							default: state_reg <= ST_SKIP;
						endcase
				end
				ST_ADDR: begin
					addr_idx_reg <= addr_idx_reg + 2'h1;
					if (addr_idx_reg == flash_cmd_pkg::ADDR_LAST_IDX)
						state_reg <= is_write_reg ? ST_WDATA : ST_DUMMY;
				end
				ST_DUMMY:  state_reg <= ST_OTPOUT;
				ST_WDATA:  state_reg <= ST_WDATA;
				ST_RDOUT:  state_reg <= ST_RDOUT;
				ST_OTPOUT: state_reg <= ST_OTPOUT;
				ST_SKIP:   state_reg <= ST_SKIP;
				default:   state_reg <= ST_SKIP;
			endcase
		end
	end

	// Command report towards the embedded engine
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			CMD_STB_O  <= 1'b0;
			CMD_CODE_O <= '0;
			CMD_BANK_O <= 1'b0;
			CMD_DROP_O <= 1'b0;
		end else begin
			CMD_STB_O  <= 1'b0;
			CMD_BANK_O <= 1'b0;
			CMD_DROP_O <= 1'b0;
			if (byte_done && state_reg == ST_OPCODE) begin
				CMD_CODE_O <= rx_byte;
				CMD_BANK_O <= (rx_byte == flash_cmd_pkg::OP_WRITE_REGS) && bank_follow_reg;
				if (admit)
					CMD_STB_O <= 1'b1;
				else
					CMD_DROP_O <= 1'b1;
			end
		end
	end

	// Remember whether the previous frame was an admitted bank access opcode
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			frame_bank_reg  <= 1'b0;
			bank_follow_reg <= 1'b0;
		end else if (frame_end) begin
			bank_follow_reg <= frame_bank_reg;
			frame_bank_reg  <= 1'b0;
		end else if (byte_done && state_reg == ST_OPCODE) begin
			frame_bank_reg <= admit && (rx_byte == flash_cmd_pkg::OP_BANK_ACCESS);
		end
	end

	// One-time address; each data byte advances it by one, wrapping to zero at the top of its 24 bits
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			OTP_ADDR_O <= '0;
		end else if (byte_done && state_reg == ST_ADDR) begin
			OTP_ADDR_O <= {OTP_ADDR_O[15:0], rx_byte};
		end else if (byte_done && state_reg == ST_WDATA) begin
			OTP_ADDR_O <= OTP_ADDR_O + 24'h000001;
		end
	end

	// Read start pulse once the address is complete
	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			RD_START_O <= 1'b0;
		else
			RD_START_O <= byte_done && state_reg == ST_ADDR && !is_write_reg
				&& addr_idx_reg == flash_cmd_pkg::ADDR_LAST_IDX;
	end

	// A data byte with zeros aimed at a locked region
	assign otp_zero_req = OTP_LOCKED_I && (rx_byte != flash_cmd_pkg::FILL_BYTE);

	// One-time write strobe; ones leave bits as they are
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			OTP_WR_STB_O  <= 1'b0;
			OTP_WR_DATA_O <= '0;
		end else begin
			OTP_WR_STB_O <= 1'b0;
			if (byte_done && state_reg == ST_WDATA && !OTP_LOCKED_I) begin
				OTP_WR_STB_O  <= 1'b1;
				OTP_WR_DATA_O <= rx_byte & OTP_OLD_I;
			end
		end
	end

	// Write enable latch: set by write enable, used up by a one-time write
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			WEL_O           <= flash_cmd_pkg::WEL_RESET;
			frame_wrote_reg <= 1'b0;
		end else if (frame_end) begin
			if (frame_wrote_reg)
				WEL_O <= 1'b0;
			frame_wrote_reg <= 1'b0;
		end else if (byte_done && state_reg == ST_OPCODE && admit) begin
			if (rx_byte == flash_cmd_pkg::OP_WRITE_ENABLE)
				WEL_O <= 1'b1;
			frame_wrote_reg <= (rx_byte == flash_cmd_pkg::OP_ONETIME_WR) && WEL_O;
		end
	end

	// Program error flag; a new error wins over a clear in the same cycle
	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			PERR_O <= flash_cmd_pkg::PERR_RESET;
		else if (byte_done && state_reg == ST_WDATA && otp_zero_req)
			PERR_O <= 1'b1;
		else if (byte_done && state_reg == ST_OPCODE && admit
				&& rx_byte == flash_cmd_pkg::OP_CLEAR_STATUS)
			PERR_O <= 1'b0;
	end

	// Read-out source chosen at decode
	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			src_reg <= flash_cmd_pkg::SRC_STATUS1;
		else if (byte_done && state_reg == ST_OPCODE)
			case (rx_byte)
				flash_cmd_pkg::OP_STATUS2_READ: src_reg <= flash_cmd_pkg::SRC_STATUS2;
				flash_cmd_pkg::OP_CONFIG_READ:  src_reg <= flash_cmd_pkg::SRC_CONFIG;
				flash_cmd_pkg::OP_SPROT_READ:   src_reg <= flash_cmd_pkg::SRC_SECTOR_PROT;
				default:                        src_reg <= flash_cmd_pkg::SRC_STATUS1;
			endcase
	end

	// Word to send, live at each reload, left aligned
	always_comb begin
		out_word = '0;
		out_last = flash_cmd_pkg::BYTE_LAST_BIT;
		case (src_reg)
			flash_cmd_pkg::SRC_STATUS1: begin
				out_word[8 + flash_cmd_pkg::SR1_WIP_BIT]  = WIP_I;
				out_word[8 + flash_cmd_pkg::SR1_WEL_BIT]  = WEL_O;
				out_word[8 + flash_cmd_pkg::SR1_PERR_BIT] = PERR_O;
			end
			flash_cmd_pkg::SRC_STATUS2: begin
				out_word[8 + flash_cmd_pkg::SR2_PS_BIT] = PROG_SUSP_I;
				out_word[8 + flash_cmd_pkg::SR2_ES_BIT] = ERASE_SUSP_I;
			end
			flash_cmd_pkg::SRC_CONFIG: out_word[15:8] = CONFIG_I;
			flash_cmd_pkg::SRC_SECTOR_PROT: begin
				out_word = {SECTOR_PROT_I[7:0], SECTOR_PROT_I[15:8]};
				out_last = flash_cmd_pkg::WORD_LAST_BIT;
			end
			default: out_word = '0;
		endcase
	end

	// Next byte of one-time data; fill when the source lags
	assign fifo_pop = (state_reg == ST_OTPOUT) && sck_fall && (out_cnt_reg == 4'h0);

	// Serial output, changed on falling link clock edges, repeating
	always_ff @(posedge CLK_I) begin
		if (RESET_I || cs_sync) begin
			SO_O        <= 1'b0;
			SO_OE_O     <= 1'b0;
			out_sh_reg  <= '0;
			out_cnt_reg <= '0;
		end else if (sck_fall && state_reg == ST_RDOUT) begin
			SO_OE_O <= 1'b1;
			if (out_cnt_reg == 4'h0) begin
				SO_O       <= out_word[15];
				out_sh_reg <= {out_word[14:0], 1'b0};
			end else begin
				SO_O       <= out_sh_reg[15];
				out_sh_reg <= {out_sh_reg[14:0], 1'b0};
			end
			out_cnt_reg <= (out_cnt_reg == out_last) ? 4'h0 : out_cnt_reg + 4'h1;
		end else if (sck_fall && state_reg == ST_OTPOUT) begin
			SO_OE_O <= 1'b1;
			if (out_cnt_reg == 4'h0) begin
				SO_O       <= fifo_valid ? fifo_data[7] : 1'b1;
				out_sh_reg <= {fifo_valid ? fifo_data[6:0] : 7'h7f, 9'h000};
			end else begin
				SO_O       <= out_sh_reg[15];
				out_sh_reg <= {out_sh_reg[14:0], 1'b0};
			end
			out_cnt_reg <= (out_cnt_reg == flash_cmd_pkg::BYTE_LAST_BIT) ?
				4'h0 : out_cnt_reg + 4'h1;
		end
	end

	// Read data staging between the array side and the shifter
	byte_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rd_fifo (
		.clk_i       (CLK_I),
		.reset_i     (RESET_I),
		.flush_i     (cs_sync),
		.in_data_i   (RD_DATA_I),
		.in_valid_i  (RD_VALID_I),
		.in_ready_o  (RD_READY_O),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);

endmodule // flash_suspend_cmd
